// *** pwal_pkg.sv ***
// Constants for the pseudo-random sequence and waveform apply block
package pwal_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] CLK_HZ     = 32'h05F5_E100; // 100 MHz system clock
  localparam logic [64:0] NS_PER_S   = 65'h0_3B9A_CA00; // Ns in one second

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00; // Poly, hold select, run
  localparam logic [7:0] OFS_RATE    = 8'h04; // Sequence bit rate
  localparam logic [7:0] OFS_AFREQ   = 8'h08; // Apply frequency argument
  localparam logic [7:0] OFS_AAMPL   = 8'h0C; // Apply amplitude argument
  localparam logic [7:0] OFS_AOFFS   = 8'h10; // Apply offset argument
  localparam logic [7:0] OFS_LOAD    = 8'h14; // Termination select
  localparam logic [7:0] OFS_WIDTH   = 8'h18; // Pulse width in ns
  localparam logic [7:0] OFS_EDGE    = 8'h1C; // Pulse edge time in ns
  localparam logic [7:0] OFS_DUTY    = 8'h20; // Pulse duty setting
  localparam logic [7:0] OFS_CMD     = 8'h24; // Apply command strobe
  localparam logic [7:0] OFS_STAT    = 8'h28; // Sticky event status
  localparam logic [7:0] OFS_MASK    = 8'h2C; // Interrupt mask
  localparam logic [7:0] OFS_SYMM    = 8'h30; // Ramp symmetry readback
  localparam logic [7:0] OFS_FREQ    = 8'h34; // Applied frequency
  localparam logic [7:0] OFS_AMPL    = 8'h38; // Applied amplitude
  localparam logic [7:0] OFS_OFFS    = 8'h3C; // Applied offset

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_POLY  = 0; // Two bits
  localparam int CTRL_HOLD  = 2; // One holds duty, zero holds width
  localparam int CTRL_RUN   = 3;
  localparam int CTRL_FUNC  = 4; // Three bits, read only
  localparam int CMD_DEF    = 3; // Use the default frequency
  localparam int CMD_REMOTE = 4; // Request came over the remote path
  localparam int ST_RANGE   = 0; // Data out of range
  localparam int ST_SEQ     = 1; // Sequence start seen

  // ----------------------------------------------------------------
  // Apply command codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_PRBS  = 3'h1;
  localparam logic [2:0] CMD_PULSE = 3'h2;
  localparam logic [2:0] CMD_RAMP  = 3'h3;
  localparam logic [2:0] CMD_TRI   = 3'h4;
  localparam logic [2:0] CMD_NOISE = 3'h5;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [31:0] RATE_RST   = 32'h0000_03E8; // 1000 bits/s
  localparam logic [31:0] FREQ_DEF   = 32'h0000_03E8; // 1 kHz
  localparam logic [31:0] RATE_MAX   = 32'h02FA_F080; // Below clock rate
  localparam logic [31:0] RAMP_FMAX  = 32'h0003_0D40; // 200 kHz
  localparam logic [31:0] PULSE_FMAX = 32'h01C9_C380; // Pulse ceiling
  localparam logic [15:0] AMPL_RST   = 16'h0064;      // 100 mVpp
  localparam logic [15:0] AMPL_MIN   = 16'h0001;      // 1 mVpp
  localparam logic [15:0] AMPL_MAX   = 16'h2710;      // 10 Vpp matched
  localparam logic [15:0] VMAX_50    = 16'h1388;      // 5 V peak matched
  localparam logic [31:0] WIDTH_RST  = 32'h0007_A120; // 500 us
  localparam logic [31:0] EDGE_RST   = 32'h0000_000A; // 10 ns
  localparam logic [31:0] EDGE_MIN   = 32'h0000_0008; // 8 ns
  localparam logic [6:0]  DUTY_RST   = 7'h32;         // 50 percent
  localparam logic [6:0]  SYMM_FULL  = 7'h64;         // 100 percent
  localparam logic [6:0]  SYMM_HALF  = 7'h32;         // 50 percent

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {POLY_7, POLY_9, POLY_15, POLY_23} pwal_poly_e;
  typedef enum logic [2:0] {FN_IDLE, FN_PRBS, FN_PULSE, FN_RAMP,
                            FN_NOISE} pwal_func_e;
endpackage

// *** pwal_top.sv ***
// Pseudo-random sequence generator with waveform apply parameter logic
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
// How it works
// - Default polynomial is the degree seven one
// - Bit rate resets to 1000, software programmable
// - Register length follows polynomial degree, maximal length
// - Each sequence opens with x high bits
// - Register advances once per bit period
// - Sync pulses at every sequence start
// - Ramp apply forces full symmetry
// - Triangle apply forces half symmetry
// - Too high frequency clamps and flags error
// - Pulse apply keeps held width or duty
// - Pulse apply keeps edge time
// - Pulse settings overridden when period too short
// - Offset clamped to limit, remote flags error
// - Termination change doubles or halves offset
// - Default frequency argument selects 1 kHz
// - Amplitude range and 100 mVpp default
// - Noise function never asserts sync
module pwal_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Waveform and interrupt
  output logic             prbs_bit,
  output logic             sync_out,
  output logic             irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                pready;   // Access phase answered
    logic [31:0]         prdata;   // Read data
    logic                pslverr;  // Unmapped address
    pwal_pkg::pwal_poly_e poly;    // Selected polynomial
    logic                hold;     // One holds duty cycle
    logic                run;      // Generator enable
    pwal_pkg::pwal_func_e func;    // Applied function
    logic [31:0]         rate;     // Bits per second
    logic [31:0]         afreq;    // Apply arguments
    logic [15:0]         aampl;
    logic signed [15:0]  aoffs;
    logic                hiz;      // High impedance termination
    logic [31:0]         width;    // Pulse width ns
    logic [31:0]         edge_t;   // Pulse edge ns
    logic [6:0]          duty;     // Pulse duty percent
    logic [6:0]          symm;     // Ramp symmetry percent
    logic [31:0]         freq;     // Applied frequency
    logic [15:0]         ampl;     // Applied amplitude mVpp
    logic signed [15:0]  offs;     // Applied offset mV
    logic [1:0]          stat;     // Sticky events
    logic [1:0]          mask;     // Interrupt enables
    logic                irq;
    logic [31:0]         acc;      // Rate accumulator
    logic [22:0]         lfsr;     // Shift register, low x bits used
    logic                bit_o;
    logic                sync_o;
  } pwal_st_s;

  pwal_st_s    r;          // Registered state
  pwal_st_s    n;          // Next state
  logic        rst_meta;   // Reset synchroniser
  logic        rst_sync;
  logic        wr;         // Write completes this cycle
  logic        apply;      // Apply command written
  logic        restart;    // Reseed the sequence
  logic        step;       // One bit period elapsed
  logic        active;     // Generator producing a sequence
  logic        range_err;  // Apply raised out of range
  logic        load_flip;  // Termination changed
  logic        fits;       // Pulse settings fit the period
  logic [32:0] acc2;
  logic [32:0] tsum;
  logic [64:0] prod;
  logic [31:0] fq;
  logic [31:0] fmax;
  logic [15:0] amax;
  logic [15:0] amin;
  logic [15:0] lim;
  logic [2:0]  code;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // All ones seed for the selected register length
  function automatic logic [22:0] seed(input pwal_pkg::pwal_poly_e p);
    case (p)
      pwal_pkg::POLY_7:  seed = 23'h00_007F;
      pwal_pkg::POLY_9:  seed = 23'h00_01FF;
      pwal_pkg::POLY_15: seed = 23'h00_7FFF;
      default:           seed = 23'h7F_FFFF;
    endcase
  endfunction

  // Right shifting two-tap register; upper unused bits stay zero
  function automatic logic [22:0] lfsr_next(input logic [22:0] s,
                                            input pwal_pkg::pwal_poly_e p);
    case (p)
      pwal_pkg::POLY_7:  lfsr_next = {16'h0000, s[0] ^ s[1], s[6:1]};
      pwal_pkg::POLY_9:  lfsr_next = {14'h0000, s[0] ^ s[4], s[8:1]};
      pwal_pkg::POLY_15: lfsr_next = {8'h00, s[0] ^ s[1], s[14:1]};
      default:           lfsr_next = {s[0] ^ s[5], s[22:1]};
    endcase
  endfunction

  // Magnitude of a signed offset
  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction

  // Largest legal offset magnitude for an amplitude
  function automatic logic [15:0] off_lim(input logic h, input logic [15:0] a);
    off_lim = (h ? 16'(pwal_pkg::VMAX_50 << 1) : pwal_pkg::VMAX_50) - (a >> 1);
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Two stage release so all state leaves reset on one edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n         = r;
    wr        = psel & penable & r.pready & pwrite;
    apply     = wr & (paddr == pwal_pkg::OFS_CMD);
    load_flip = wr & (paddr == pwal_pkg::OFS_LOAD) & (pwdata[0] != r.hiz);
    code      = pwdata[2:0];
    restart   = 1'b0;
    range_err = 1'b0;
    // Bus answer: one wait state, read data captured with pready
    n.pready  = psel & penable & ~r.pready;
    n.pslverr = 1'b0;
    if (psel & penable & ~r.pready) begin
      n.prdata = 32'h0000_0000;
      case (paddr)
        pwal_pkg::OFS_CTRL:  n.prdata = {25'h000_0000, 3'(r.func), r.run,
                                         r.hold, r.poly};
        pwal_pkg::OFS_RATE:  n.prdata = r.rate;
        pwal_pkg::OFS_AFREQ: n.prdata = r.afreq;
        pwal_pkg::OFS_AAMPL: n.prdata = {16'h0000, r.aampl};
        pwal_pkg::OFS_AOFFS: n.prdata = {{16{r.aoffs[15]}}, r.aoffs};
        pwal_pkg::OFS_LOAD:  n.prdata = {31'h0000_0000, r.hiz};
        pwal_pkg::OFS_WIDTH: n.prdata = r.width;
        pwal_pkg::OFS_EDGE:  n.prdata = r.edge_t;
        pwal_pkg::OFS_DUTY:  n.prdata = {25'h000_0000, r.duty};
        pwal_pkg::OFS_CMD:   n.prdata = 32'h0000_0000;
        pwal_pkg::OFS_STAT:  n.prdata = {30'h0000_0000, r.stat};
        pwal_pkg::OFS_MASK:  n.prdata = {30'h0000_0000, r.mask};
        pwal_pkg::OFS_SYMM:  n.prdata = {25'h000_0000, r.symm};
        pwal_pkg::OFS_FREQ:  n.prdata = r.freq;
        pwal_pkg::OFS_AMPL:  n.prdata = {16'h0000, r.ampl};
        pwal_pkg::OFS_OFFS:  n.prdata = {{16{r.offs[15]}}, r.offs};
        default:             n.pslverr = 1'b1;
      endcase
    end
    // Plain register writes
    if (wr) begin
      case (paddr)
        pwal_pkg::OFS_CTRL: begin
          n.poly = pwal_pkg::pwal_poly_e'(pwdata[pwal_pkg::CTRL_POLY +: 2]);
          n.hold = pwdata[pwal_pkg::CTRL_HOLD];
          n.run  = pwdata[pwal_pkg::CTRL_RUN];
          restart = 1'b1;
        end
        pwal_pkg::OFS_RATE: begin
          // programmable rate, kept inside the generator's reach
          n.rate = (pwdata > pwal_pkg::RATE_MAX) ? pwal_pkg::RATE_MAX :
                   (pwdata == 32'h0000_0000) ? 32'h0000_0001 : pwdata;
        end
        pwal_pkg::OFS_AFREQ: n.afreq  = pwdata;
        pwal_pkg::OFS_AAMPL: n.aampl  = pwdata[15:0];
        pwal_pkg::OFS_AOFFS: n.aoffs  = pwdata[15:0];
        pwal_pkg::OFS_WIDTH: n.width  = pwdata;
        pwal_pkg::OFS_EDGE:  n.edge_t = pwdata;
        pwal_pkg::OFS_DUTY:  n.duty   = pwdata[6:0];
        pwal_pkg::OFS_MASK:  n.mask   = pwdata[1:0];
        pwal_pkg::OFS_LOAD:  n.hiz    = pwdata[0];
        default: ;
      endcase
    end
    // only the reported offset scales, never an error
    if (load_flip) begin
      n.offs = r.hiz ? (r.offs >>> 1) : 16'(r.offs <<< 1);
    end
    fq = pwdata[pwal_pkg::CMD_DEF] ? pwal_pkg::FREQ_DEF : r.afreq;
    case (code)
      pwal_pkg::CMD_PRBS:  fmax = pwal_pkg::RATE_MAX;
      pwal_pkg::CMD_PULSE: fmax = pwal_pkg::PULSE_FMAX;
      default:             fmax = pwal_pkg::RAMP_FMAX;
    endcase
    amax = r.hiz ? 16'(pwal_pkg::AMPL_MAX << 1) : pwal_pkg::AMPL_MAX;
    amin = r.hiz ? 16'(pwal_pkg::AMPL_MIN << 1) : pwal_pkg::AMPL_MIN;
    // clamp the frequency to the function's ceiling
    if (code != pwal_pkg::CMD_NOISE && fq > fmax) begin
      fq = fmax;
      range_err = apply & (code >= pwal_pkg::CMD_PRBS) & (code <= pwal_pkg::CMD_TRI);
    end else if (code != pwal_pkg::CMD_NOISE && fq == 32'h0000_0000) begin
      fq = 32'h0000_0001;
      range_err = apply & (code >= pwal_pkg::CMD_PRBS) & (code <= pwal_pkg::CMD_TRI);
    end
    // period must hold an edge, plus the width when width is held
    tsum = r.hold ? {1'b0, r.edge_t} : {1'b0, r.width} + {1'b0, r.edge_t};
    prod = 65'(tsum) * 65'(fq);
    fits = prod < pwal_pkg::NS_PER_S;
    lim  = 16'h0000;
    if (apply && code >= pwal_pkg::CMD_PRBS && code <= pwal_pkg::CMD_NOISE) begin
      n.ampl = (r.aampl > amax) ? amax : (r.aampl < amin) ? amin : r.aampl;
      if (r.aampl > amax || r.aampl < amin) begin
        range_err = 1'b1;
      end
      // offset held inside peak limit less half amplitude
      lim    = off_lim(r.hiz, n.ampl);
      n.offs = r.aoffs;
      if (mag(r.aoffs) > lim) begin
        n.offs = r.aoffs[15] ? -$signed(lim) : $signed(lim);
        if (pwdata[pwal_pkg::CMD_REMOTE]) begin
          range_err = 1'b1;
        end
      end
      case (code)
        pwal_pkg::CMD_PRBS: begin
          n.func  = pwal_pkg::FN_PRBS;
          n.rate  = fq;
          restart = 1'b1;
        end
        pwal_pkg::CMD_PULSE: begin
          n.func = pwal_pkg::FN_PULSE;
          n.freq = fq;
          // held choice kept unless the period is too short
          // edge time untouched when everything fits
          if (!fits) begin
            // fall back to half duty and the shortest edge
            n.hold   = 1'b1;
            n.duty   = pwal_pkg::DUTY_RST;
            n.edge_t = pwal_pkg::EDGE_MIN;
          end
        end
        pwal_pkg::CMD_RAMP: begin
          n.func = pwal_pkg::FN_RAMP;
          n.freq = fq;
          // rising ramp across the whole period
          n.symm = pwal_pkg::SYMM_FULL;
        end
        pwal_pkg::CMD_TRI: begin
          n.func = pwal_pkg::FN_RAMP;
          n.freq = fq;
          // triangle is the ramp at half symmetry
          n.symm = pwal_pkg::SYMM_HALF;
        end
        default: n.func = pwal_pkg::FN_NOISE;
      endcase
    end
    // accumulator gives one step per bit period
    active = r.run & (r.func == pwal_pkg::FN_PRBS);
    acc2   = {1'b0, r.acc} + {1'b0, r.rate};
    step   = active & (acc2 >= {1'b0, pwal_pkg::CLK_HZ});
    if (!active) begin
      n.acc = 32'h0000_0000;
    end else if (step) begin
      n.acc = 32'(acc2 - {1'b0, pwal_pkg::CLK_HZ});
    end else begin
      n.acc = acc2[31:0];
    end
    // register length and taps follow the polynomial
    if (restart) begin
      // every new sequence starts from all ones
      n.lfsr = seed(n.poly);
      n.acc  = 32'h0000_0000;
    end else if (step) begin
      n.lfsr = lfsr_next(r.lfsr, r.poly);
    end
    // the all ones seed gives x high bits first
    n.bit_o  = active & r.lfsr[0];
    // sync marks each return to the seed
    // noise and other functions leave sync low
    // held for the one bit period of the seed state
    n.sync_o = active & (r.lfsr == seed(r.poly));
    // Sticky events; a set in the clearing cycle wins
    if (wr && paddr == pwal_pkg::OFS_STAT) begin
      n.stat = r.stat & ~pwdata[1:0];
    end
    if (range_err) begin
      n.stat[pwal_pkg::ST_RANGE] = 1'b1;
    end
    if (n.sync_o && !r.sync_o) begin
      n.stat[pwal_pkg::ST_SEQ] = 1'b1;
    end
    n.irq = |(n.stat & n.mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      r        <= '0;
      // degree seven polynomial until software chooses
      r.poly   <= pwal_pkg::POLY_7;
      // 1000 bits per second after reset
      r.rate   <= pwal_pkg::RATE_RST;
      r.lfsr   <= 23'h00_007F;
      r.afreq  <= pwal_pkg::FREQ_DEF;
      r.freq   <= pwal_pkg::FREQ_DEF;
      r.aampl  <= pwal_pkg::AMPL_RST;
      r.ampl   <= pwal_pkg::AMPL_RST;
      r.width  <= pwal_pkg::WIDTH_RST;
      r.edge_t <= pwal_pkg::EDGE_RST;
      r.duty   <= pwal_pkg::DUTY_RST;
      r.symm   <= pwal_pkg::SYMM_FULL;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from flip-flops
  assign prdata   = r.prdata;
  assign pready   = r.pready;
  assign pslverr  = r.pslverr;
  assign prbs_bit = r.bit_o;
  assign sync_out = r.sync_o;
  assign irq      = r.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync);

  // Seed state reached while generating
  sequence s_seq_start;
    active && (r.lfsr == seed(r.poly)) && !r.sync_o;
  endsequence
  // Sync and status follow one edge later
  sequence s_sync_seen;
    sync_out && r.stat[pwal_pkg::ST_SEQ];
  endsequence

  AST_RESET_POLY: assert property ($rose(rst_sync) |-> r.poly == pwal_pkg::POLY_7)
    else $error("polynomial not degree seven after reset");
  AST_RESET_RATE: assert property ($rose(rst_sync) |-> r.rate == pwal_pkg::RATE_RST)
    else $error("bit rate not 1000 after reset");
  AST_STEP_ONLY: assert property (!step && !restart |=> $stable(r.lfsr))
    else $error("shift register moved without a step");
  AST_SEED_ONES: assert property (restart |=> r.lfsr == seed(r.poly))
    else $error("sequence not seeded all ones");
  AST_SYNC_HIGH: assert property (sync_out |-> prbs_bit)
    else $error("sync without a high bit");
  AST_SYNC_START: assert property (s_seq_start |=> s_sync_seen)
    else $error("sequence start without sync");
  AST_SYNC_ONE_PERIOD: assert property (active && r.lfsr != seed(r.poly) |=> !sync_out)
    else $error("sync held past the first bit");
  AST_NOISE_NOSYNC: assert property (r.func == pwal_pkg::FN_NOISE |=> !sync_out)
    else $error("sync asserted in noise mode");
  AST_RAMP_SYMM: assert property (apply && code == pwal_pkg::CMD_RAMP |=>
    r.symm == pwal_pkg::SYMM_FULL) else $error("ramp symmetry not full");
  AST_TRI_SYMM: assert property (apply && code == pwal_pkg::CMD_TRI |=>
    r.symm == pwal_pkg::SYMM_HALF) else $error("triangle symmetry not half");
  AST_RAMP_CLAMP: assert property (apply && code == pwal_pkg::CMD_RAMP &&
    !pwdata[pwal_pkg::CMD_DEF] && r.afreq > pwal_pkg::RAMP_FMAX |=>
    r.freq == pwal_pkg::RAMP_FMAX && r.stat[pwal_pkg::ST_RANGE])
    else $error("ramp frequency not clamped");
  AST_PULSE_KEEP: assert property (apply && code == pwal_pkg::CMD_PULSE && fits
    |=> $stable(r.edge_t) && $stable(r.hold)) else $error("pulse settings lost");
  AST_OFFS_LIMIT: assert property (apply && code != 3'h0 && code <= pwal_pkg::CMD_NOISE
    |=> mag(r.offs) <= off_lim(r.hiz, r.ampl)) else $error("offset beyond limit");
  AST_LOAD_DOUBLE: assert property (load_flip && !r.hiz |=>
    r.offs == 16'($past(r.offs) <<< 1)) else $error("offset not doubled");
  AST_FREQ_DEF: assert property (apply && code == pwal_pkg::CMD_PULSE &&
    pwdata[pwal_pkg::CMD_DEF] |=> r.freq == pwal_pkg::FREQ_DEF)
    else $error("default frequency not 1 kHz");
endmodule

// *** tb_prbs_waveform_apply_logic.sv ***
// Self-checking testbench for the sequence generator and apply logic
`timescale 1ns/100ps
module tb_prbs_waveform_apply_logic;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic        clk, rstn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, prbs_bit, sync_out, irq, se;
  int          err_count = 0;
  int          checked   = 0;
  int          cyc       = 0;
  logic [7:0]  ra [9];     // Row: register offset
  logic [31:0] rv [9];     // Row: value expected after reset

  pwal_top i_dut (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prbs_bit(prbs_bit),
    .sync_out(sync_out), .irq(irq));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, run needs about 68k cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only pready or the hang guard ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int sl, pl, sr, x;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ra = '{8'h00, 8'h04, 8'h34, 8'h38, 8'h3C, 8'h30, 8'h18, 8'h1C, 8'h28};
    rv = '{32'h0, 32'h3E8, 32'h3E8, 32'h64, 32'h0, 32'h64, 32'h7A120, 32'hA, 32'h0};
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset value rows
    for (int i = 0; i < 9; i++) rchk(ra[i], rv[i]);
    // Unmapped offset is refused
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, se}, 32'h1);
    // Ramp clamps frequency and amplitude, flags range
    apb(1'b1, 8'h08, 32'h4C_4B40);
    apb(1'b1, 8'h0C, 32'h4E20);
    apb(1'b1, 8'h24, 32'h3);
    rchk(8'h34, 32'h3_0D40);
    rchk(8'h38, 32'h2710);
    rchk(8'h30, 32'h64);
    rchk(8'h28, 32'h1);
    // Interrupt raised, then cleared by writing one
    apb(1'b1, 8'h2C, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h28, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h24, 32'h4);
    rchk(8'h30, 32'h32);
    // Pulse with default frequency keeps width and edge; at 1 MHz the edge falls to 8 ns
    apb(1'b1, 8'h1C, 32'h14);
    apb(1'b1, 8'h24, 32'hA);
    rchk(8'h34, 32'h3E8);
    rchk(8'h1C, 32'h14);
    rchk(8'h18, 32'h7A120);
    apb(1'b1, 8'h08, 32'hF_4240);
    apb(1'b1, 8'h24, 32'h2);
    rchk(8'h1C, 32'h8);
    // Offset clamp from remote, then termination swaps
    apb(1'b1, 8'h08, 32'h3E8);
    apb(1'b1, 8'h0C, 32'hFA0);
    apb(1'b1, 8'h10, 32'hFA0);
    apb(1'b1, 8'h24, 32'h13);
    rchk(8'h3C, 32'hBB8);
    apb(1'b1, 8'h28, 32'h3);
    apb(1'b1, 8'h14, 32'h1);
    rchk(8'h3C, 32'h1770);
    apb(1'b1, 8'h14, 32'h0);
    rchk(8'h3C, 32'hBB8);
    rchk(8'h28, 32'h0);
    // Sequence at 1 Mbit/s: 100 clocks a bit, degrees 7, 9, 15 and 23
    apb(1'b1, 8'h08, 32'hF_4240);
    for (int p = 0; p < 4; p++) begin
      x = (p == 0) ? 7 : (p == 1) ? 9 : (p == 2) ? 15 : 23;
      apb(1'b1, 8'h00, 32'h8 | p);
      apb(1'b1, 8'h24, 32'h1);
      // Sync shows the restart state one clock after it, stale sync ignored
      repeat (2) @(posedge clk);
      chk({31'h0, sync_out}, 32'h1);
      sl = 0;
      pl = 0;
      sr = 0;
      for (int k = 1; k < 52000 && sr == 0 && (p < 2 || pl == 0); k++) begin
        @(posedge clk);
        if (sync_out !== 1'b1 && sl == 0) sl = k;
        if (prbs_bit !== 1'b1 && pl == 0) pl = k;
        if (sync_out === 1'b1 && sl != 0) sr = k;
      end
      chk(sl, 100);
      chk(pl, x * 100);
      // Full period only for short registers, long ones would overrun the run
      if (p < 2) chk(sr, ((1 << x) - 1) * 100);
    end
    // Noise never pulses sync, entered at a live sequence start
    apb(1'b1, 8'h00, 32'h8);
    apb(1'b1, 8'h24, 32'h5);
    // Sync still mirrors the last generator state for one clock
    @(posedge clk);
    sl = 0;
    repeat (300) begin
      @(posedge clk);
      if (sync_out !== 1'b0) sl++;
    end
    chk(sl, 0);
    wrap_up();
  end
endmodule
